// ### rtl/ioc_pkg.sv
// Package of command fields, function codes and area codes for the decoder
package ioc_pkg;
  // Command word layout: word 0 is address, word 1 is area/func/modifier
  localparam int ADDR_W = 16;
  localparam int AREA_W = 5;
  localparam int FUNC_W = 3;
  localparam int MOD_W = 8;
  localparam int AREA_LSB = 11;
  localparam int FUNC_LSB = 8;
  localparam int MOD_LSB = 0;
  localparam int RESET_BIT = 0;
  localparam int NUM_AREAS = 24;
  localparam int NUM_LEVELS = 4;
  // Function codes
  localparam logic [2:0] FN_MAINT = 3'h0;
  localparam logic [2:0] FN_WRITE = 3'h1;
  localparam logic [2:0] FN_READ = 3'h2;
  localparam logic [2:0] FN_SENSE_LVL = 3'h3;
  localparam logic [2:0] FN_CONTROL = 3'h4;
  localparam logic [2:0] FN_INIT_WRITE = 3'h5;
  localparam logic [2:0] FN_INIT_READ = 3'h6;
  localparam logic [2:0] FN_SENSE_DEV = 3'h7;
  // Area codes
  localparam logic [4:0] AREA_CONSOLE = 5'h00;
  localparam logic [4:0] AREA_SELECTOR = 5'h12;
  localparam logic [4:0] AREA_LAST = 5'h17;
  // Reset values
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [23:0] MASK_RST = 24'h000000;
  // One core storage cycle per status or data word
  localparam int CORE_CYCLE_NS = 100;
  localparam int CLK_NS = 100;
  localparam int CORE_CYC = (CORE_CYCLE_NS + CLK_NS - 1) / CLK_NS;
  // Index register bits cleared after shift-left-and-count (bits 8,9 MSB=0)
  localparam logic [15:0] XR_CLEAR_MASK = 16'h003f;
  localparam logic [15:0] XR_KEEP_MASK = 16'hff00;
endpackage

// ### rtl/ioc_if.sv
// Interface joining the decoder end and the adapter-group end
`timescale 1ns/1ps
interface ioc_if;
  logic cmd_valid;
  logic [15:0] cmd_addr;
  logic [4:0] cmd_area;
  logic [2:0] cmd_func;
  logic [7:0] cmd_mod;
  logic [23:0] area_sel;
  logic status_valid;
  logic [15:0] status_word;
  logic [15:0] level_word;
  logic [23:0] busy;
  logic [23:0] dc_req;
  logic [23:0] dc_read;
  logic [15:0] dc_wdata;
  logic dc_ack;
  logic [15:0] dc_rdata;
  logic [3:0] lvl_req;
  modport decoder (
    output cmd_valid, cmd_addr, cmd_area, cmd_func, cmd_mod, area_sel,
    output dc_ack, dc_rdata,
    input status_valid, status_word, level_word, busy, dc_req, dc_read,
    input dc_wdata, lvl_req
  );
  modport adapters (
    input cmd_valid, cmd_addr, cmd_area, cmd_func, cmd_mod, area_sel,
    input dc_ack, dc_rdata,
    output status_valid, status_word, level_word, busy, dc_req, dc_read,
    output dc_wdata, lvl_req
  );
endinterface

// ### rtl/ioc_decoder.sv
// Processor-side end: fetches, decodes and dispatches the I/O control command
// Functional notes
// (R1) Sole I/O instruction fetches two-word command
// (R2) Decode address, area, function, modifier fields
// (R3) Five-bit area selects one adapter or group
// (R4) Three-bit function encodes eight operations
// (R5) Initialize ops pass table address, channel only
// (R6) Control passes address to adapter unchanged
// (R7) Sense ops ignore address, one cycle status
// (R8) Read/write move one word, program control
// (R9) Busy channel device ignores command
// (R10) Channel stalls program one cycle per word
// (R11) Program-control device interrupts per word
// (R12) Fixed area codes decoded to selects
// (R13) Shift-count normalizes; clears index bits 8,9
// (R14) Indexed indirect branch picks table entry
// (R15) Sense device returns area/modifier status
// (R16) Software tests every indicator of status
// (R17) Function zero toggles maintenance mode
// (R18) Modifier extends function or names unit
// (R19) Status held until sense with reset bit
// (R20) Sense level returns highest pending level; the code returns the indicator bits of areas 0-15
// (R21) Unassigned areas select no adapter
`timescale 1ns/1ps
module ioc_decoder (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic EXEC,
  input wire logic [15:0] CMD_W0,
  input wire logic [15:0] CMD_W1,
  input wire logic [15:0] ACC_IN,
  input wire logic [15:0] XR_IN,
  input wire logic SHIFT_EN,
  input wire logic [15:0] MEM_RDATA,
  output logic BUSY,
  output logic DONE,
  output logic ACC_WE,
  output logic [15:0] ACC_OUT,
  output logic [15:0] XR_OUT,
  output logic [15:0] BRANCH_INDEX,
  output logic MEM_WE,
  output logic [15:0] MEM_ADDR,
  output logic [15:0] MEM_WDATA,
  output logic STALL,
  ioc_if.decoder io
);
  // ****************************************
  // State
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ISSUE = 2'b01,
    ST_SENSE = 2'b10,
    ST_DONE = 2'b11
  } st_t;

  typedef struct packed {
    st_t st;
    logic hold;
    logic busy;
    logic done;
    logic acc_we;
    logic [15:0] acc;
    logic [15:0] xr;
    logic [15:0] bidx;
    logic mem_we;
    logic [15:0] mem_addr;
    logic [15:0] mem_wdata;
    logic stall;
    logic cmd_valid;
    logic [15:0] addr;
    logic [4:0] area;
    logic [2:0] func;
    logic [7:0] modf;
    logic [23:0] sel;
    logic dc_ack;
    logic [15:0] dc_rdata;
  } state_t;

  state_t r_q, r_d;
  logic [4:0] dc_pick;
  logic dc_any;

  // Lowest-numbered channel request wins one cycle
  always_comb begin
    dc_pick = 5'h00;
    dc_any = 1'b0;
    for (int i = ioc_pkg::NUM_AREAS - 1; i >= 0; i--) begin
      if (io.dc_req[i]) begin
        dc_pick = 5'(i);
        dc_any = 1'b1;
      end
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    r_d = r_q;
    r_d.cmd_valid = 1'b0;
    r_d.done = 1'b0;
    r_d.acc_we = 1'b0;
    r_d.mem_we = 1'b0;
    r_d.dc_ack = 1'b0;
    r_d.stall = 1'b0;
    // Channel cycle steal: one stall cycle per word
    if (dc_any && !r_q.dc_ack) begin
      r_d.stall = 1'b1; // R10
      r_d.dc_ack = 1'b1;
      r_d.mem_addr = 16'(dc_pick);
      if (io.dc_read[dc_pick]) begin
        r_d.mem_we = 1'b1;
        r_d.mem_wdata = io.dc_wdata;
      end else begin
        r_d.dc_rdata = MEM_RDATA;
      end
    end
    // Shift-left-and-count: normalize, count down, then mask
    if (SHIFT_EN) begin
      r_d.acc = ACC_IN;
      r_d.xr = XR_IN;
      for (int k = 0; k < 16; k++) begin
        if (!r_d.acc[15] && r_d.acc != 16'h0000 && r_d.xr != 16'h0000) begin
          r_d.acc = {r_d.acc[14:0], 1'b0}; // R13
          r_d.xr = r_d.xr - 16'h0001; // R13
        end
      end
      r_d.xr = (r_d.xr & ioc_pkg::XR_KEEP_MASK) |
               (r_d.xr & ioc_pkg::XR_CLEAR_MASK); // R13
      r_d.bidx = r_d.xr; // R14
      r_d.acc_we = 1'b1;
    end
    unique case (r_q.st)
      ST_IDLE: begin
        if (EXEC) begin
          r_d.addr = CMD_W0; // R1 R2
          r_d.area = CMD_W1[ioc_pkg::AREA_LSB +: ioc_pkg::AREA_W]; // R2
          r_d.func = CMD_W1[ioc_pkg::FUNC_LSB +: ioc_pkg::FUNC_W]; // R4
          r_d.modf = CMD_W1[ioc_pkg::MOD_LSB +: ioc_pkg::MOD_W]; // R18
          r_d.busy = 1'b1;
          r_d.st = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        // One-hot select, none for codes past the last area or for sense level
        r_d.sel = '0;
        if (r_q.area <= ioc_pkg::AREA_LAST && r_q.func !=
            ioc_pkg::FN_SENSE_LVL) begin
          r_d.sel[r_q.area] = 1'b1; // R3 R12 R21
        end
        r_d.cmd_valid = 1'b1; // R5 R6 R17
        if (r_q.func == ioc_pkg::FN_WRITE) begin
          r_d.mem_addr = r_q.addr; // R8
        end
        r_d.st = ST_SENSE;
      end
      ST_SENSE: begin
        r_d.sel = '0;
        r_d.st = ST_DONE;
        r_d.hold = 1'b0;
        // Read word or sense status lands in the accumulator
        unique case (r_q.func)
          ioc_pkg::FN_SENSE_LVL: begin
            r_d.acc = io.level_word; // R7 R20
            r_d.acc_we = 1'b1;
          end
          ioc_pkg::FN_SENSE_DEV, ioc_pkg::FN_READ: begin
            if (!r_q.hold) begin
              // Adapter answer is registered, so wait one cycle for it
              r_d.hold = 1'b1;
              r_d.st = ST_SENSE;
            end else if (io.status_valid) begin
              r_d.acc = io.status_word; // R7 R15
              r_d.acc_we = 1'b1;
              if (r_q.func == ioc_pkg::FN_READ) begin
                r_d.mem_we = 1'b1; // R8
                r_d.mem_addr = r_q.addr;
                r_d.mem_wdata = io.status_word;
              end
            end
          end
          default: begin
          end
        endcase
      end
      ST_DONE: begin
        r_d.busy = 1'b0;
        r_d.done = 1'b1;
        r_d.st = ST_IDLE;
      end
    endcase
  end

  // Register everything; CE freezes all state
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      r_q <= '0;
    end else if (CE) begin
      r_q <= r_d;
    end
  end

  // ****************************************
  // Outputs straight from flops, except cmd_addr, which passes MEM_RDATA through for a write
  // ****************************************
  assign BUSY = r_q.busy;
  assign DONE = r_q.done;
  assign ACC_WE = r_q.acc_we;
  assign ACC_OUT = r_q.acc;
  assign XR_OUT = r_q.xr;
  assign BRANCH_INDEX = r_q.bidx;
  assign MEM_WE = r_q.mem_we;
  assign MEM_ADDR = r_q.mem_addr;
  assign MEM_WDATA = r_q.mem_wdata;
  assign STALL = r_q.stall;
  assign io.cmd_valid = r_q.cmd_valid;
  assign io.cmd_addr = (r_q.func == ioc_pkg::FN_WRITE) ? MEM_RDATA : r_q.addr;
  assign io.cmd_area = r_q.area;
  assign io.cmd_func = r_q.func;
  assign io.cmd_mod = r_q.modf;
  assign io.area_sel = r_q.sel;
  assign io.dc_ack = r_q.dc_ack;
  assign io.dc_rdata = r_q.dc_rdata;
endmodule

// ### rtl/ioc_adapters.sv
// Adapter-side end: status holding, busy, channel words and level requests
`timescale 1ns/1ps
module ioc_adapters #(
  parameter int N = 24
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic [N-1:0] EVENT,
  input wire logic [N-1:0] DEV_BUSY,
  input wire logic [N-1:0] CHAN_DEV,
  input wire logic [N-1:0] WORD_REQ,
  input wire logic [15:0] DEV_WDATA,
  output logic [N-1:0] MAINT,
  output logic [N-1:0] STARTED,
  output logic [15:0] CTRL_ARG,
  output logic [15:0] DEV_RDATA,
  ioc_if.adapters io
);
  typedef struct packed {
    logic [N-1:0] ind;
    logic [N-1:0] maint;
    logic [N-1:0] started;
    logic [N-1:0] pend;
    logic [15:0] ctrl;
    logic [15:0] rdata;
    logic sv;
    logic [15:0] sw;
  } state_t;

  state_t r_q, r_d;
  logic [15:0] lvl;
  logic acked;

  // Level word: pending interrupt indicators of the lowest level group
  always_comb begin
    lvl = 16'(r_q.ind);
  end

  // ****************************************
  // Command handling
  // ****************************************
  always_comb begin
    r_d = r_q;
    r_d.sv = 1'b0;
    r_d.ind = r_q.ind;
    acked = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (io.cmd_valid && io.area_sel[i] &&
          !(CHAN_DEV[i] && DEV_BUSY[i])) begin // R9
        unique case (io.cmd_func)
          ioc_pkg::FN_MAINT: r_d.maint[i] = ~r_q.maint[i]; // R17
          ioc_pkg::FN_CONTROL: r_d.ctrl = io.cmd_addr; // R6
          ioc_pkg::FN_INIT_READ, ioc_pkg::FN_INIT_WRITE: begin
            if (CHAN_DEV[i]) begin
              r_d.started[i] = 1'b1; // R5
            end
          end
          ioc_pkg::FN_WRITE: r_d.rdata = io.cmd_addr; // R8
          ioc_pkg::FN_READ: begin
            r_d.sv = 1'b1;
            r_d.sw = DEV_WDATA; // R8
          end
          ioc_pkg::FN_SENSE_DEV: begin
            r_d.sv = 1'b1;
            r_d.sw = {15'(r_q.ind[i]), r_q.maint[i]}; // R15
            if (io.cmd_mod[ioc_pkg::RESET_BIT]) begin
              r_d.ind[i] = 1'b0; // R19
            end
          end
          default: begin
          end
        endcase
      end
      // New event wins over a same-cycle reset
      if (EVENT[i]) begin
        r_d.ind[i] = 1'b1; // R11 R19
      end
      // Each ack takes only the lowest pending word, as the decoder picks
      if (io.dc_ack && r_q.pend[i] && !acked) begin
        r_d.pend[i] = 1'b0;
        acked = 1'b1;
      end
      // A fresh word request wins over a same-cycle ack
      if (WORD_REQ[i] && r_q.started[i]) begin
        r_d.pend[i] = 1'b1; // R10
      end
    end
  end

  // Registers; CE freezes all state
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      r_q <= '0;
    end else if (CE) begin
      r_q <= r_d;
    end
  end

  assign MAINT = r_q.maint;
  assign STARTED = r_q.started;
  assign CTRL_ARG = r_q.ctrl;
  assign DEV_RDATA = r_q.rdata;
  assign io.status_valid = r_q.sv;
  assign io.status_word = r_q.sw;
  assign io.level_word = lvl;
  assign io.busy = 24'(DEV_BUSY);
  assign io.dc_req = 24'(r_q.pend);
  assign io.dc_read = 24'(CHAN_DEV);
  assign io.dc_wdata = DEV_WDATA;
  assign io.lvl_req = {3'h0, |r_q.ind};
endmodule

// ### sim/ioc_props.sv
// Interface checks between decoder and adapter ends
`timescale 1ns/1ps
module ioc_props (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic cmd_valid,
  input wire logic [4:0] cmd_area,
  input wire logic [2:0] cmd_func,
  input wire logic [23:0] area_sel,
  input wire logic status_valid,
  input wire logic [23:0] dc_req,
  input wire logic dc_ack
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // ****
  // Sense steps
  // ****
  sequence sense_req;
    cmd_valid && cmd_func == 3'h7 && cmd_area <= 5'h17;
  endsequence
  sequence one_status;
    status_valid ##1 !status_valid;
  endsequence
  chk_sense_answer: assert property (sense_req |=> one_status)
    else $error("sense gave no single status pulse");
  // Only sense device (111) and read (010) get a status answer
  chk_status_cause: assert property (status_valid |->
    $past(cmd_valid) &&
    ($past(cmd_func) == 3'h7 || $past(cmd_func) == 3'h2))
    else $error("status without a sense command");
  chk_sel_onehot: assert property ($onehot0(area_sel))
    else $error("more than one adapter selected");
  // Level sense selects no device, so it is left out here
  chk_area_decode: assert property (cmd_valid && cmd_area <= 5'h17
    && cmd_func != 3'h3 |-> area_sel == 24'h1 << cmd_area)
    else $error("area decoded to wrong select");
  chk_spare_area: assert property (cmd_valid && cmd_area > 5'h17
    |-> area_sel == 24'h0)
    else $error("spare area selected an adapter");
  chk_spare_quiet: assert property (cmd_valid && cmd_area > 5'h17
    |=> !status_valid)
    else $error("spare area answered");
  chk_cmd_pulse: assert property (cmd_valid |=> !cmd_valid)
    else $error("command strobe held");
  chk_ack_cause: assert property (dc_ack |-> $past(dc_req) != 24'h0)
    else $error("channel ack without request");
endmodule

// ### sim/tb_top.sv
// Self-checking bench joining decoder and adapter ends
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic exec = 1'b0;
  logic shift_en = 1'b0;
  logic [15:0] w0 = 16'h0, w1 = 16'h0, acc_in = 16'h0, xr_in = 16'h0;
  logic [23:0] event_in = 24'h0, dev_busy = 24'h0, word_req = 24'h0;
  logic [23:0] chan_dev = 24'h4;
  logic done, acc_we, mem_we, stall;
  logic [15:0] acc_out, xr_out, mem_addr, ctrl_arg, acc_v, c_w1;
  logic [23:0] maint, started, c_sel;
  logic got_we, got_mem, busy;
  logic [15:0] bidx, mem_wdata, dev_rdata;
  logic [15:0] mem_rdata = 16'h0, dev_wdata = 16'h0;
  int miscompares = 0, checks_done = 0, stalls;
  ioc_if bus ();
  ioc_decoder ioc_decoder_i (.CLK(clk), .RSTN(rstn), .CE(1'b1),
    .EXEC(exec), .CMD_W0(w0), .CMD_W1(w1), .ACC_IN(acc_in),
    .XR_IN(xr_in), .SHIFT_EN(shift_en), .MEM_RDATA(mem_rdata),
    .BUSY(busy), .DONE(done), .ACC_WE(acc_we), .ACC_OUT(acc_out),
    .XR_OUT(xr_out), .BRANCH_INDEX(bidx), .MEM_WE(mem_we),
    .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .STALL(stall), .io(bus));
  ioc_adapters ioc_adapters_i (.CLK(clk), .RSTN(rstn), .CE(1'b1),
    .EVENT(event_in), .DEV_BUSY(dev_busy), .CHAN_DEV(chan_dev),
    .WORD_REQ(word_req), .DEV_WDATA(dev_wdata), .MAINT(maint),
    .STARTED(started), .CTRL_ARG(ctrl_arg), .DEV_RDATA(dev_rdata),
    .io(bus));
  ioc_props ioc_props_i (.CLK(clk), .RSTN(rstn),
    .cmd_valid(bus.cmd_valid), .cmd_area(bus.cmd_area),
    .cmd_func(bus.cmd_func), .area_sel(bus.area_sel),
    .status_valid(bus.status_valid), .dc_req(bus.dc_req),
    .dc_ack(bus.dc_ack));
  // 10 MHz clock
  initial begin
    forever #50 clk = ~clk;
  end
  // ****
  // Shared tasks
  // ****
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // One command; strobe lasts a single cycle so it is not taken twice
  task automatic execute_io_instruction(input logic [15:0] a, input logic [4:0] ar,
    input logic [2:0] fn, input logic [7:0] md);
    int n;
    @(negedge clk);
    exec = 1'b1;
    w0 = a;
    w1 = {ar, fn, md};
    got_we = 1'b0;
    got_mem = 1'b0;
    for (n = 0; n < 12; n++) begin
      @(negedge clk);
      exec = 1'b0;
      if (n == 0) check(busy, 1'b1);
      if (bus.cmd_valid === 1'b1) begin
        c_w1 = {bus.cmd_area, bus.cmd_func, bus.cmd_mod};
        c_sel = bus.area_sel;
      end
      if (acc_we === 1'b1) begin
        got_we = 1'b1;
        acc_v = acc_out;
      end
      if (mem_we === 1'b1) got_mem = 1'b1;
      if (done === 1'b1) break;
    end
    if (n == 12) begin
      check(1'b0, 1'b1);
      wrap_up();
    end
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_fields();
    for (int f = 0; f < 8; f++) begin
      execute_io_instruction(16'h1234, 5'h03, f[2:0], 8'h5a);
      check(c_w1, {5'h03, f[2:0], 8'h5a});
    end
  endtask
  // All 32 codes; spare ones must leave the last argument alone
  task automatic t_areas();
    for (int a = 0; a < 32; a++) begin
      execute_io_instruction(16'h00c0 + a[15:0], a[4:0], ioc_pkg::FN_CONTROL, 8'h00);
      check(c_sel, a < 24 ? 24'h1 << a : 24'h0);
      check(ctrl_arg, 16'h00c0 + (a < 24 ? a : 23));
    end
  endtask
  task automatic t_maint();
    execute_io_instruction(16'h0, 5'h05, ioc_pkg::FN_MAINT, 8'h00);
    check(maint, 24'h000028);
    execute_io_instruction(16'h0, 5'h05, ioc_pkg::FN_MAINT, 8'h00);
    check(maint, 24'h000008);
  endtask
  task automatic t_rw();
    mem_rdata = 16'h5a3c;
    execute_io_instruction(16'h0abc, 5'h01, ioc_pkg::FN_WRITE, 8'h00);
    check(mem_addr, 16'h0abc);
    check(dev_rdata, 16'h5a3c);
    dev_wdata = 16'hc3a5;
    execute_io_instruction(16'h0def, 5'h01, ioc_pkg::FN_READ, 8'h00);
    check({got_mem, mem_addr}, {1'b1, 16'h0def});
    check(mem_wdata, 16'hc3a5);
  endtask
  // Plain sense keeps the indicator; reset bit clears it
  task automatic t_status();
    @(negedge clk);
    event_in = 24'h4;
    @(negedge clk);
    event_in = 24'h0;
    execute_io_instruction(16'hffff, 5'h02, ioc_pkg::FN_SENSE_LVL, 8'h00);
    check(got_we && acc_v != 16'h0, 1'b1);
    execute_io_instruction(16'hffff, 5'h02, ioc_pkg::FN_SENSE_DEV, 8'h00);
    check(got_we && acc_v != 16'h0, 1'b1);
    execute_io_instruction(16'h0, 5'h02, ioc_pkg::FN_SENSE_DEV, 8'h01);
    check(got_we && acc_v != 16'h0, 1'b1);
    execute_io_instruction(16'h0, 5'h02, ioc_pkg::FN_SENSE_DEV, 8'h00);
    check(acc_v, 16'h0);
    // Two indicators: clearing one must leave the other held
    @(negedge clk);
    event_in = 24'h14;
    @(negedge clk);
    event_in = 24'h0;
    execute_io_instruction(16'h0, 5'h02, ioc_pkg::FN_SENSE_DEV, 8'h01);
    check(got_we && acc_v != 16'h0, 1'b1);
    execute_io_instruction(16'h0, 5'h04, ioc_pkg::FN_SENSE_DEV, 8'h01);
    check(got_we && acc_v != 16'h0, 1'b1);
    execute_io_instruction(16'h0, 5'h02, ioc_pkg::FN_SENSE_LVL, 8'h00);
    check(acc_v, 16'h0);
  endtask
  task automatic t_chan();
    dev_busy = 24'h4;
    execute_io_instruction(16'h0400, 5'h02, ioc_pkg::FN_INIT_WRITE, 8'h00);
    check(started[2], 1'b0);
    dev_busy = 24'h0;
    execute_io_instruction(16'h0400, 5'h01, ioc_pkg::FN_INIT_READ, 8'h00);
    check(started[1], 1'b0);
    execute_io_instruction(16'h0400, 5'h02, ioc_pkg::FN_INIT_WRITE, 8'h00);
    check(started[2], 1'b1);
    stalls = 0;
    word_req = 24'h4;
    @(negedge clk);
    word_req = 24'h0;
    repeat (8) begin
      @(negedge clk);
      stalls += int'(stall === 1'b1);
    end
    check(stalls, 1);
  endtask
  // Four shifts from 0800; index low byte d0 drops to 0c
  task automatic t_shift();
    int n;
    @(negedge clk);
    shift_en = 1'b1;
    acc_in = 16'h0800;
    xr_in = 16'ha5d0;
    for (n = 0; n < 8; n++) begin
      @(negedge clk);
      shift_en = 1'b0;
      if (acc_we === 1'b1) break;
    end
    if (n == 8) begin
      check(1'b0, 1'b1);
      wrap_up();
    end
    check({acc_out, xr_out}, {16'h8000, 16'ha50c});
    check(bidx, 16'ha50c);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    t_fields();
    t_areas();
    t_maint();
    t_rw();
    t_status();
    t_chan();
    t_shift();
    wrap_up();
  end
endmodule
